// *** design/ccl_params.svh ***
// Offsets, field positions, reset values and bus constants of the limit bank.
`ifndef CCL_PARAMS_SVH
`define CCL_PARAMS_SVH
`define CCL_DEV_ADDR7         7'h0d
`define CCL_OFS_CHARGE        8'h14
`define CCL_OFS_INPUT_SEC     8'h3b
`define CCL_OFS_INPUT_PRI     8'h3f
`define CCL_FIELD_LSB         2
`define CCL_FIELD_MSB         12
`define CCL_FIELD_MAX         11'h5f0
`define CCL_CHARGE_RESET      11'h000
`define CCL_INPUT_SEC_RESET   11'h177
`endif

// *** design/ccl_pkg.sv ***
// Types shared by the current limit register bank.
`default_nettype none
package ccl_pkg;
   typedef logic [10:0] ccl_code_t;
   typedef struct packed {
      logic       start;
      logic       stop;
      logic       valid;
      logic [7:0] data;
   } ccl_rx_s;
   typedef enum logic [2:0] {
      CCL_IDLE   = 3'b000,
      CCL_ADDR   = 3'b001,
      CCL_CMD    = 3'b010,
      CCL_WR_LO  = 3'b011,
      CCL_WR_HI  = 3'b100,
      CCL_READ   = 3'b101,
      CCL_IGNORE = 3'b110
   } ccl_state_e;
endpackage : ccl_pkg
`default_nettype wire

// *** design/ccl_current_limit_regs.sv ***
// Charge and input current limit registers behind a byte-level serial port.
`default_nettype none
`include "ccl_params.svh"
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Charge cap is eleven bits at 12:2, bit 2 weighs 4mA, doubling.
// - Largest charge code is 10111110000 (6080mA); bigger writes clamp.
// - Both input caps use the same eleven-bit field at bits 12:2.
// - Any input cap write accepted; unused bits dropped, clamp 6080mA.
// - Adapter power-on loads the primary input cap from the strap.
// - Adapter power-on sets secondary to 1.5A unless battery came first.
// - Reads return the stored contents of both input caps.
// - Power-on reset clears the charge cap to zero.
// - Device answers write address byte 0x1A (and read 0x1B).
module ccl_current_limit_regs
   import ccl_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   input  wire logic       clk_en_i,
   input  wire ccl_rx_s    rx_i,
   input  wire logic       tx_req_i,
   input  wire logic       adapter_por_i,
   input  wire logic       battery_first_i,
   input  wire ccl_code_t  config_strap_pin_i,
   output logic            rx_ack_o,
   output logic [7:0]      tx_byte_o,
   output ccl_code_t       battery_charge_current_cap_o,
   output ccl_code_t       input_current_cap_primary_o,
   output ccl_code_t       input_current_cap_secondary_o
);

   ////////////////////////////////////////////////////////////////////////
   function automatic ccl_code_t clamp_code(input logic [15:0] word);
      ccl_code_t f;
      f = word[`CCL_FIELD_MSB:`CCL_FIELD_LSB];
      return (f > `CCL_FIELD_MAX) ? `CCL_FIELD_MAX : f;
   endfunction : clamp_code

   function automatic logic [15:0] to_word(input ccl_code_t f);
      return {3'h0, f, 2'h0};
   endfunction : to_word

   ////////////////////////////////////////////////////////////////////////
   // Reset release is synchronised so every flop past the two-flop synchroniser leaves reset together.
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   ////////////////////////////////////////////////////////////////////////
   ccl_state_e  state, next_state;
   logic [7:0]  cmd, next_cmd;
   logic [7:0]  wr_lo, next_wr_lo;
   logic        rd_hi, next_rd_hi;
   logic        strap_pend, next_strap_pend;
   ccl_code_t   chg, next_chg;
   ccl_code_t   pri, next_pri;
   ccl_code_t   sec, next_sec;
   logic        next_ack;
   logic [7:0]  next_tx;
   logic [15:0] rd_word, wr_word;
   logic        addr_hit;
   ccl_code_t   wr_code;

   always_comb begin
      unique case (cmd)
         `CCL_OFS_CHARGE:    rd_word = to_word(chg);
         `CCL_OFS_INPUT_SEC: rd_word = to_word(sec);
         `CCL_OFS_INPUT_PRI: rd_word = to_word(pri);
         default:            rd_word = 16'h0000;
      endcase
   end

   assign wr_word  = {rx_i.data, wr_lo};
   assign addr_hit = (rx_i.data[7:1] == `CCL_DEV_ADDR7);
   assign wr_code  = clamp_code(wr_word);

   always_comb begin
      next_state      = state;
      next_cmd        = cmd;
      next_wr_lo      = wr_lo;
      next_rd_hi      = rd_hi;
      next_ack        = 1'b0;
      next_tx         = tx_byte_o;
      next_chg        = chg;
      next_pri        = pri;
      next_sec        = sec;
      next_strap_pend = 1'b0;
      // The strap is caught one edge after reset release, never by reset.
      if (strap_pend || adapter_por_i) begin
         next_pri = clamp_code(to_word(config_strap_pin_i));
      end
      if (adapter_por_i && !battery_first_i) begin
         next_sec = `CCL_INPUT_SEC_RESET;
      end
      if (rx_i.start) begin
         next_state = CCL_ADDR;
      end else if (rx_i.stop) begin
         next_state = CCL_IDLE;
      end else if (tx_req_i && state == CCL_READ) begin
         next_tx    = rd_hi ? 8'h00 : rd_word[15:8];
         next_rd_hi = 1'b1;
      end else if (rx_i.valid) begin
         unique case (state)
            CCL_ADDR: begin
               next_ack   = addr_hit;
               next_rd_hi = 1'b0;
               next_tx    = rd_word[7:0];
               if (!addr_hit) begin
                  next_state = CCL_IGNORE;
               end else if (rx_i.data[0]) begin
                  next_state = CCL_READ;
               end else begin
                  next_state = CCL_CMD;
               end
            end
            CCL_CMD: begin
               next_ack   = 1'b1;
               next_cmd   = rx_i.data;
               next_state = CCL_WR_LO;
            end
            CCL_WR_LO: begin
               next_ack   = 1'b1;
               next_wr_lo = rx_i.data;
               next_state = CCL_WR_HI;
            end
            CCL_WR_HI: begin
               next_ack   = 1'b1;
               next_state = CCL_IGNORE;
               unique case (cmd)
                  `CCL_OFS_CHARGE:    next_chg = wr_code;
                  `CCL_OFS_INPUT_SEC: next_sec = wr_code;
                  `CCL_OFS_INPUT_PRI: next_pri = wr_code;
                  default:            next_sec = next_sec;
               endcase
            end
            CCL_READ, CCL_IDLE, CCL_IGNORE: begin
               next_ack = 1'b0;
            end
            default: begin
               next_state = CCL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state      <= CCL_IDLE;
         cmd        <= 8'h00;
         wr_lo      <= 8'h00;
         rd_hi      <= 1'b0;
         rx_ack_o   <= 1'b0;
         tx_byte_o  <= 8'h00;
         chg        <= `CCL_CHARGE_RESET;
         pri        <= 11'h000;
         sec        <= `CCL_INPUT_SEC_RESET;
         strap_pend <= 1'b1;
      end else if (clk_en_i) begin
         state      <= next_state;
         cmd        <= next_cmd;
         wr_lo      <= next_wr_lo;
         rd_hi      <= next_rd_hi;
         rx_ack_o   <= next_ack;
         tx_byte_o  <= next_tx;
         chg        <= next_chg;
         pri        <= next_pri;
         sec        <= next_sec;
         strap_pend <= next_strap_pend;
      end
   end

   // Fields are eleven bits each and leave the block at 4mA per step.
   assign battery_charge_current_cap_o  = chg;
   assign input_current_cap_primary_o   = pri;
   assign input_current_cap_secondary_o = sec;

   ////////////////////////////////////////////////////////////////////////
   sequence s_hi_byte;
      clk_en_i && state == CCL_WR_HI && rx_i.valid
         && !rx_i.start && !rx_i.stop && !tx_req_i;
   endsequence

   sequence s_quiet_por;
      clk_en_i && adapter_por_i && !strap_pend;
   endsequence

   property p_cap_max;
      @(posedge mclk_i) disable iff (!rst_n)
         chg <= `CCL_FIELD_MAX && pri <= `CCL_FIELD_MAX
         && sec <= `CCL_FIELD_MAX;
   endproperty
   a_cap_max: assert property (p_cap_max)
      else $error("Current cap above 6080mA code.");

   property p_charge_write;
      @(posedge mclk_i) disable iff (!rst_n)
         s_hi_byte and (cmd == `CCL_OFS_CHARGE)
         |=> chg == clamp_code({$past(rx_i.data), $past(wr_lo)});
   endproperty
   a_charge_write: assert property (p_charge_write)
      else $error("Charge cap write not stored clamped.");

   property p_sec_write;
      @(posedge mclk_i) disable iff (!rst_n)
         s_hi_byte and (cmd == `CCL_OFS_INPUT_SEC) and !adapter_por_i
         |=> sec == clamp_code({$past(rx_i.data), $past(wr_lo)});
   endproperty
   a_sec_write: assert property (p_sec_write)
      else $error("Secondary cap write not stored clamped.");

   property p_charge_por;
      @(posedge mclk_i) $rose(rst_n) |-> chg == 11'h000;
   endproperty
   a_charge_por: assert property (p_charge_por)
      else $error("Charge cap not zero after reset.");

   property p_pri_strap;
      @(posedge mclk_i) disable iff (!rst_n)
         s_quiet_por and !(state == CCL_WR_HI && rx_i.valid)
         |=> pri == clamp_code(to_word($past(config_strap_pin_i)));
   endproperty
   a_pri_strap: assert property (p_pri_strap)
      else $error("Primary cap not loaded from strap.");

   property p_sec_default;
      @(posedge mclk_i) disable iff (!rst_n)
         s_quiet_por and !battery_first_i
         and !(state == CCL_WR_HI && rx_i.valid)
         |=> sec == `CCL_INPUT_SEC_RESET;
   endproperty
   a_sec_default: assert property (p_sec_default)
      else $error("Secondary cap not set to 1.5A.");

   property p_sec_keep;
      @(posedge mclk_i) disable iff (!rst_n)
         s_quiet_por and battery_first_i and state != CCL_WR_HI
         |=> $stable(sec);
   endproperty
   a_sec_keep: assert property (p_sec_keep)
      else $error("Secondary cap lost with battery first.");

   property p_addr_nack;
      @(posedge mclk_i) disable iff (!rst_n)
         clk_en_i && state == CCL_ADDR && rx_i.valid && !rx_i.start
         && !rx_i.stop && !addr_hit |=> !rx_ack_o ##0 state == CCL_IGNORE;
   endproperty
   a_addr_nack: assert property (p_addr_nack)
      else $error("Foreign address acknowledged.");

   property p_read_lo;
      @(posedge mclk_i) disable iff (!rst_n)
         clk_en_i && state == CCL_ADDR && rx_i.valid && !rx_i.start
         && !rx_i.stop && addr_hit && rx_i.data[0]
         |=> tx_byte_o == $past(rd_word[7:0]) && tx_byte_o[1:0] == 2'h0;
   endproperty
   a_read_lo: assert property (p_read_lo)
      else $error("Read low byte wrong.");

endmodule : ccl_current_limit_regs
`default_nettype wire

// *** test/ccl_host_model.sv ***
// Host model that sends byte events into the limit bank.
`default_nettype none
module ccl_host_model
   import ccl_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       ack_i,
   input  wire logic [7:0] tx_i,
   output var  ccl_rx_s    rx_o,
   output var  logic       tx_req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_o = '0;
      tx_req_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Idle data is not masked: wr idles on its last byte, rd on 0xe4, 0x1b and 0xff.
   task ev(input logic [2:0] f, input logic [7:0] d);
      rx_o = {f, d};
      @(negedge mclk_i);
   endtask : ev
   task wr(input logic [7:0] a, c, input logic [15:0] w,
           output logic [3:0] k);
      ev(3'b100, 8'h00);
      ev(3'b001, a);
      k[0] = ack_i;
      ev(3'b001, c);
      k[1] = ack_i;
      ev(3'b001, w[7:0]);
      k[2] = ack_i;
      ev(3'b001, w[15:8]);
      k[3] = ack_i;
      ev(3'b010, ~w[15:8]);
      ev(3'b000, w[15:8]);
   endtask : wr
   task rd(input logic [7:0] c, output logic [15:0] w,
           output logic [2:0] k);
      ev(3'b100, 8'h00);
      ev(3'b001, 8'h1a);
      k[0] = ack_i;
      ev(3'b001, c);
      k[1] = ack_i;
      ev(3'b100, ~c);
      ev(3'b001, 8'h1b);
      k[2] = ack_i;
      ev(3'b000, 8'he4);
      w[7:0] = tx_i;
      tx_req_o = 1'b1;
      ev(3'b000, 8'h1b);
      tx_req_o = 1'b0;
      @(negedge mclk_i);
      w[15:8] = tx_i;
      ev(3'b010, 8'h00);
      ev(3'b000, 8'hff);
   endtask : rd
endmodule : ccl_host_model
`default_nettype wire

// *** test/test_charger_current_limit_regs.sv ***
// Self-checking bench for the current limit register bank.
`default_nettype none
module test_charger_current_limit_regs
   import ccl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        por = 1'b0;
   logic        bat_first = 1'b0;
   ccl_code_t   strap = 11'h7ff;
   ccl_rx_s     rx;
   logic        tx_req;
   logic        ack;
   logic [7:0]  tx_byte;
   ccl_code_t   cap_c;
   ccl_code_t   cap_p;
   ccl_code_t   cap_s;
   int          bad_count = 0;
   int          compares = 0;
   logic [7:0]  ofs [3] = '{8'h14, 8'h3b, 8'h3f};
   logic [15:0] vals [3] = '{16'h1234, 16'h17c4, 16'he003};
   always #4 mclk = ~mclk;
   ccl_current_limit_regs ccl_current_limit_regs_i (
      .mclk_i(mclk), .reset_n_i(reset_n), .clk_en_i(clk_en), .rx_i(rx),
      .tx_req_i(tx_req), .adapter_por_i(por), .battery_first_i(bat_first),
      .config_strap_pin_i(strap), .rx_ack_o(ack), .tx_byte_o(tx_byte),
      .battery_charge_current_cap_o(cap_c),
      .input_current_cap_primary_o(cap_p),
      .input_current_cap_secondary_o(cap_s));
   ccl_host_model ccl_host_model_i (.mclk_i(mclk), .ack_i(ack),
      .tx_i(tx_byte), .rx_o(rx), .tx_req_o(tx_req));
   ////////////////////////////////////////////////////////////////////////
   function automatic ccl_code_t cap(input int i);
      return (i == 0) ? cap_c : (i == 1) ? cap_s : cap_p;
   endfunction : cap
   function automatic ccl_code_t clamp(input logic [15:0] w);
      return (w[12:2] > 11'h5f0) ? 11'h5f0 : w[12:2];
   endfunction : clamp
   task chk(input logic [15:0] g, e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task stop_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk({5'h00, cap_c}, 16'h0000);
      chk({5'h00, cap_s}, 16'h0177);
      chk({5'h00, cap_p}, 16'h05f0);
   endtask : t_reset
   // Values straddle the clamp point and set every unused bit.
   task t_write;
      logic [3:0]  k;
      logic [2:0]  r;
      logic [15:0] w;
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 3; j++) begin
            ccl_host_model_i.wr(8'h1a, ofs[i], vals[j], k);
            chk({12'h000, k}, 16'h000f);
            chk({5'h00, cap(i)}, {5'h00, clamp(vals[j])});
            ccl_host_model_i.rd(ofs[i], w, r);
            chk({13'h0000, r}, 16'h0007);
            chk(w, {3'b000, clamp(vals[j]), 2'b00});
         end
      end
   endtask : t_write
   task t_refuse;
      logic [3:0]  k;
      logic [2:0]  r;
      logic [15:0] w;
      ccl_host_model_i.wr(8'h1a, 8'h14, 16'h0010, k);
      ccl_host_model_i.wr(8'h20, 8'h14, 16'h0100, k);
      chk({12'h000, k}, 16'h0000);
      chk({5'h00, cap_c}, 16'h0004);
      ccl_host_model_i.wr(8'h1a, 8'h15, 16'h0200, k);
      ccl_host_model_i.rd(8'h15, w, r);
      chk(w, 16'h0000);
      ccl_host_model_i.rd(8'h14, w, r);
      chk(w, 16'h0010);
   endtask : t_refuse
   task t_por;
      logic [3:0] k;
      ccl_host_model_i.wr(8'h1a, 8'h3b, 16'h0100, k);
      strap = 11'h100;
      bat_first = 1'b1;
      clk_en = 1'b0;
      por = 1'b1;
      @(negedge mclk);
      clk_en = 1'b1;
      chk({5'h00, cap_p}, 16'h0000);
      @(negedge mclk);
      por = 1'b0;
      @(negedge mclk);
      chk({5'h00, cap_p}, 16'h0100);
      chk({5'h00, cap_s}, 16'h0040);
      bat_first = 1'b0;
      por = 1'b1;
      @(negedge mclk);
      por = 1'b0;
      @(negedge mclk);
      chk({5'h00, cap_s}, 16'h0177);
   endtask : t_por
   // A reset in mid-run must undo programmed values, not only start-up ones.
   task t_rereset;
      logic [3:0] k;
      ccl_host_model_i.wr(8'h1a, 8'h3b, 16'h0100, k);
      chk({5'h00, cap_s}, 16'h0040);
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk({5'h00, cap_c}, 16'h0000);
      chk({5'h00, cap_s}, 16'h0177);
      chk({5'h00, cap_p}, 16'h0100);
   endtask : t_rereset
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_reset();
      t_write();
      t_refuse();
      t_por();
      t_rereset();
      stop_test();
   end
   // The whole sequence needs well under a tenth of this span.
   initial begin
      #100us;
      bad_count++;
      stop_test();
   end
endmodule : test_charger_current_limit_regs
`default_nettype wire
